// ===== wake_timer_pkg.sv
/*
 * Constants, register map and carrier types of the self wake-up timer.
 * Assumes a 20 MHz system clock and a 10 kHz timer tick made from it.
 */
package wake_timer_pkg;

    // ==========================================================
    // Clock rates and tick divider
    // ==========================================================
    localparam int SYS_FREQ_HZ  = 20_000_000;
    localparam int TICK_FREQ_HZ = 10_000;
    localparam int TICK_DIV     = SYS_FREQ_HZ / TICK_FREQ_HZ;
    localparam int TICK_W       = 12;
    localparam int PRESC_W      = 11;

    // ==========================================================
    // Register indices; the byte address is four times the index
    // ==========================================================
    localparam int ADDR_W = 12;
    localparam logic [9:0] IDX_RELOAD     = 10'h086;
    localparam logic [9:0] IDX_CONTROL    = 10'h08F;
    localparam logic [9:0] IDX_IRQ_STATUS = 10'h090;
    localparam logic [9:0] IDX_IRQ_CLEAR  = 10'h091;
    localparam logic [9:0] IDX_IRQ_ENABLE = 10'h092;
    localparam logic [9:0] IDX_GLOBAL_EN  = 10'h093;

    // ==========================================================
    // Field positions and reset values
    // ==========================================================
    localparam int CTRL_W       = 5;
    localparam int FLAG_BIT     = 4;
    localparam int IRQ_EVT_BIT  = 0;
    localparam int LANE0_BIT    = 0;
    localparam logic [7:0] COUNT_MAX    = 8'hFF;
    localparam logic [7:0] RELOAD_RESET = 8'h00;
    localparam logic [31:0] DATA_ZERO   = 32'h0000_0000;

    // ==========================================================
    // Carrier types
    // ==========================================================
    typedef struct packed {
        logic       flag;
        logic       run;
        logic [2:0] prescale;
    } ctrl_t;

    localparam ctrl_t CTRL_RESET = '{flag: 1'b0, run: 1'b0, prescale: 3'h0};

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic              write;
        logic [31:0]       wdata;
        logic [3:0]        strb;
    } apb_req_t;

    // Last prescaler count for each prescale select code.
    function automatic logic [PRESC_W-1:0] presc_last(input logic [2:0] sel);
        case (sel)
            3'h0:    presc_last = 11'h000;
            3'h1:    presc_last = 11'h003;
            3'h2:    presc_last = 11'h00F;
            3'h3:    presc_last = 11'h03F;
            3'h4:    presc_last = 11'h0FF;
            3'h5:    presc_last = 11'h1FF;
            3'h6:    presc_last = 11'h3FF;
            default: presc_last = 11'h7FF;
        endcase
    endfunction

endpackage

// ===== self_wake_timer.sv
/*
 * Self wake-up timer with an APB register slave and a level interrupt.
 * Assumes one 20 MHz clock, an asynchronous active-low reset and a
 * zero-wait APB master; the 10 kHz timer tick is a divided enable.
 */
`timescale 1ns/1ps

module self_wake_timer
    import wake_timer_pkg::*;
#(
    parameter int TICK_DIVIDE = TICK_DIV
) (
    input  wire logic              CLOCK,
    input  wire logic              RESETN,
    input  wire logic              PSEL,
    input  wire logic              PENABLE,
    input  wire logic              PWRITE,
    input  wire logic [ADDR_W-1:0] PADDR,
    input  wire logic [31:0]       PWDATA,
    input  wire logic [3:0]        PSTRB,
    output logic      [31:0]       PRDATA,
    output logic                   PREADY,
    output logic                   PSLVERR,
    input  wire logic              IDLE_MODE,
    input  wire logic              POWER_DOWN,
    output logic                   OSC_KEEP_ON,
    output logic                   IRQ
);

    // ==========================================================
    // Bus decode
    // ==========================================================
    apb_req_t          req;
    logic [9:0]        idx;
    logic              mapped;
    logic              access;
    logic              wr_en;
    logic              wr_reload;
    logic              wr_ctrl;
    logic              wr_clear;
    logic              wr_enable;
    logic              wr_global;
    logic [31:0]       rd_mux;

    // Register state.
    ctrl_t             ctrl_q;
    logic [7:0]        reload_q;
    logic [7:0]        count_q;
    logic              wake_en_q;
    logic              global_en_q;
    logic [TICK_W-1:0] tick_cnt_q;
    logic [PRESC_W-1:0] presc_q;
    logic              tick;
    logic              presc_pulse;
    logic              rollover;

    // Pack the request and decode the word index.
    assign req.addr  = PADDR;
    assign req.write = PWRITE;
    assign req.wdata = PWDATA;
    assign req.strb  = PSTRB;
    assign idx       = req.addr[ADDR_W-1:2];
    assign access    = PSEL & PENABLE;
    assign wr_en     = access & req.write & req.strb[LANE0_BIT];

    // A register is mapped when its index matches a known word.
    assign mapped = (idx == IDX_RELOAD) || (idx == IDX_CONTROL) ||
                    (idx == IDX_IRQ_STATUS) || (idx == IDX_IRQ_CLEAR) ||
                    (idx == IDX_IRQ_ENABLE) || (idx == IDX_GLOBAL_EN);

    // Write strobes, one per writable register; the status word has none.
    assign wr_reload = wr_en & (idx == IDX_RELOAD);
    assign wr_ctrl   = wr_en & (idx == IDX_CONTROL);
    assign wr_clear  = wr_en & (idx == IDX_IRQ_CLEAR);
    assign wr_enable = wr_en & (idx == IDX_IRQ_ENABLE);
    assign wr_global = wr_en & (idx == IDX_GLOBAL_EN);

    // The slave never inserts wait states; unmapped words answer with an error.
    assign PREADY  = 1'b1;
    assign PSLVERR = access & ~mapped;

    // Read multiplexer; the clear register and unmapped words read as zero.
    always_comb begin
        rd_mux = DATA_ZERO;
        case (idx)
            IDX_RELOAD:     rd_mux[7:0] = reload_q;
            IDX_CONTROL:    rd_mux[CTRL_W-1:0] = ctrl_q;
            IDX_IRQ_STATUS: rd_mux[IRQ_EVT_BIT] = ctrl_q.flag;
            IDX_IRQ_ENABLE: rd_mux[IRQ_EVT_BIT] = wake_en_q;
            IDX_GLOBAL_EN:  rd_mux[IRQ_EVT_BIT] = global_en_q;
            default:        rd_mux = DATA_ZERO;
        endcase
    end

    // Read data is captured in the setup cycle and stands through the access.
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            PRDATA <= DATA_ZERO;
        end else if (PSEL && !PENABLE && !req.write) begin
            PRDATA <= rd_mux;
        end
    end

    // ==========================================================
    // Configuration registers
    // ==========================================================

    // Control word in one process, so that each field has a single driver.
    // A rollover wins over a clear in the same cycle; reset leaves the timer halted.
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            ctrl_q <= CTRL_RESET;
        end else begin
            if (wr_ctrl) begin
                ctrl_q.run      <= req.wdata[FLAG_BIT-1];
                ctrl_q.prescale <= req.wdata[FLAG_BIT-2:0];
            end
            if (rollover) begin
                ctrl_q.flag <= 1'b1;
            end else if (wr_clear && req.wdata[IRQ_EVT_BIT]) begin
                ctrl_q.flag <= 1'b0;
            end else if (wr_ctrl) begin
                ctrl_q.flag <= req.wdata[FLAG_BIT];
            end
        end
    end

    // Reload byte; a write while running simply takes effect at the next reload.
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            reload_q <= RELOAD_RESET;
        end else if (wr_reload) begin
            reload_q <= req.wdata[7:0];
        end
    end

    // Interrupt enables, both cleared at reset.
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            wake_en_q   <= 1'b0;
            global_en_q <= 1'b0;
        end else begin
            if (wr_enable) begin
                wake_en_q <= req.wdata[IRQ_EVT_BIT];
            end
            if (wr_global) begin
                global_en_q <= req.wdata[IRQ_EVT_BIT];
            end
        end
    end

    // ==========================================================
    // Timer clock and prescaler
    // ==========================================================

    // Free-running divider that makes the 10 kHz tick enable.
    assign tick = (tick_cnt_q == TICK_W'(TICK_DIVIDE - 1));

    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            tick_cnt_q <= '0;
        end else if (tick) begin
            tick_cnt_q <= '0;
        end else begin
            tick_cnt_q <= tick_cnt_q + 1'b1;
        end
    end

    // The oscillator is held on while the timer runs, in any power mode.
    assign OSC_KEEP_ON = ctrl_q.run;

    // Prescaler; it restarts from zero whenever the timer is halted.
    assign presc_pulse = ctrl_q.run & tick & (presc_q >= presc_last(ctrl_q.prescale));

    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            presc_q <= '0;
        end else if (!ctrl_q.run) begin
            presc_q <= '0;
        end else if (presc_pulse) begin
            presc_q <= '0;
        end else if (tick) begin
            presc_q <= presc_q + 1'b1;
        end
    end

    // ==========================================================
    // Counter and overflow flag
    // ==========================================================

    // Rollover is a single-cycle pulse in the system clock domain.
    assign rollover = presc_pulse & (count_q == COUNT_MAX);

    // Up-counter; power mode inputs deliberately play no part.
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            count_q <= RELOAD_RESET;
        end else if (!ctrl_q.run) begin
            count_q <= reload_q;
        end else if (rollover) begin
            count_q <= reload_q;
        end else if (presc_pulse) begin
            count_q <= count_q + 1'b1;
        end
    end

    // Level interrupt while the flag is set and both enables are on.
    assign IRQ = ctrl_q.flag & wake_en_q & global_en_q;

    // ==========================================================
    // Assertions
    // ==========================================================
    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (!RESETN);

    property p_count_up;
        presc_pulse && (count_q != COUNT_MAX) |=> count_q == $past(count_q) + 8'h01;
    endproperty
    a_count_up: assert property (p_count_up) else $error("counter did not step by one");

    // Division ratio worked out by shifts, apart from the prescaler's own table.
    function automatic logic [PRESC_W:0] presc_ratio(input logic [2:0] sel);
        logic [3:0] shamt;
        shamt = (sel < 3'h5) ? {sel, 1'b0} : 4'(sel) + 4'h4;
        presc_ratio = (PRESC_W+1)'(1) << shamt;
    endfunction

    logic [PRESC_W:0] tick_seen_q;
    logic             ratio_ok_q;

    // Checker helper: ticks seen since the last counter step, valid while the select is unchanged.
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            tick_seen_q <= '0;
            ratio_ok_q  <= 1'b0;
        end else if (!ctrl_q.run) begin
            tick_seen_q <= '0;
            ratio_ok_q  <= 1'b1;
        end else begin
            if (presc_pulse) begin
                tick_seen_q <= '0;
            end else if (tick) begin
                tick_seen_q <= tick_seen_q + 1'b1;
            end
            if (presc_pulse) begin
                ratio_ok_q <= 1'b1;
            end else if (wr_ctrl) begin
                ratio_ok_q <= 1'b0;
            end
        end
    end

    property p_presc_gate;
        presc_pulse && ratio_ok_q |-> tick && (tick_seen_q == presc_ratio(ctrl_q.prescale) - 1'b1);
    endproperty
    a_presc_gate: assert property (p_presc_gate) else $error("prescaler fired early");

    property p_div4;
        ctrl_q.run && (ctrl_q.prescale == 3'h1) && presc_pulse && !wr_ctrl
        ##1 (!wr_ctrl)[*8] |-> !presc_pulse;
    endproperty
    a_div4: assert property (p_div4) else $error("divide by four pulsed too soon");

    property p_halt;
        !ctrl_q.run |-> !presc_pulse ##1 (count_q == $past(reload_q));
    endproperty
    a_halt: assert property (p_halt) else $error("halted counter moved");

    property p_reload;
        rollover |=> (count_q == $past(reload_q)) && ctrl_q.flag;
    endproperty
    a_reload: assert property (p_reload) else $error("overflow missed reload or flag");

    property p_flag_sticky;
        ctrl_q.flag && !wr_clear && !wr_ctrl |=> ctrl_q.flag;
    endproperty
    a_flag_sticky: assert property (p_flag_sticky) else $error("flag cleared by itself");

    property p_irq;
        $rose(ctrl_q.flag) && wake_en_q && global_en_q |-> IRQ;
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt not raised");

    property p_sleep_count;
        (IDLE_MODE || POWER_DOWN) && presc_pulse && !rollover |=> count_q != $past(count_q);
    endproperty
    a_sleep_count: assert property (p_sleep_count) else $error("counter stopped in sleep");

    property p_osc_on;
        ctrl_q.run |-> OSC_KEEP_ON;
    endproperty
    a_osc_on: assert property (p_osc_on) else $error("oscillator released while running");

    property p_once;
        rollover |=> !rollover;
    endproperty
    a_once: assert property (p_once) else $error("rollover lasted two cycles");

    property p_flag_cause;
        $rose(ctrl_q.flag) |-> $past(rollover) || $past(wr_ctrl);
    endproperty
    a_flag_cause: assert property (p_flag_cause) else $error("flag set without cause");

    c_rollover: cover property (rollover);
    c_irq_rise: cover property ($rose(IRQ));
    c_unmapped: cover property (PSLVERR);
    c_clear_race: cover property (rollover && wr_clear);

endmodule

// ===== tb.sv
/*
 * Self-checking testbench of the self wake-up timer, driving its APB slave and mode inputs.
 * Assumes the zero-wait APB slave of the design, TICK_DIVIDE shortened to 4 and the package map.
 */
`timescale 1ns/1ps

module tb
    import wake_timer_pkg::*;
;
    localparam int TDIV = 4;

    typedef struct packed {
        logic [31:0] data;
        logic        err;
    } rd_note_t;

    logic              clock;
    logic              resetn;
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata;
    logic [3:0]        pstrb;
    logic [31:0]       prdata;
    logic              pready;
    logic              pslverr;
    logic              idle_mode;
    logic              power_down;
    logic              osc_keep_on;
    logic              irq;
    logic [31:0]       lfsr;
    rd_note_t          notes[$];
    int                mismatches;
    int                checked;
    int                nt [8] = '{1, 4, 16, 64, 256, 512, 1024, 2048};
    logic [9:0]        idxs [6] = '{IDX_RELOAD, IDX_CONTROL, IDX_IRQ_STATUS,
                                    IDX_IRQ_CLEAR, IDX_IRQ_ENABLE, IDX_GLOBAL_EN};

    // ==========================================================
    // Design and clock
    // ==========================================================
    self_wake_timer #(
        .TICK_DIVIDE (TDIV)
    ) dut (
        .CLOCK       (clock),
        .RESETN      (resetn),
        .PSEL        (psel),
        .PENABLE     (penable),
        .PWRITE      (pwrite),
        .PADDR       (paddr),
        .PWDATA      (pwdata),
        .PSTRB       (pstrb),
        .PRDATA      (prdata),
        .PREADY      (pready),
        .PSLVERR     (pslverr),
        .IDLE_MODE   (idle_mode),
        .POWER_DOWN  (power_down),
        .OSC_KEEP_ON (osc_keep_on),
        .IRQ         (irq)
    );

    // The clock toggles every half period of 25 ns.
    always #25 clock = ~clock;

    // ==========================================================
    // Helpers and bus tasks
    // ==========================================================
    function automatic logic [31:0] lfsr_next(input logic [31:0] x);
        lfsr_next = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    // One APB transfer; the request holds until PREADY is seen at a rising edge.
    task automatic apb(input logic [9:0] idx, input logic wr, input logic [31:0] data, input logic [3:0] strb);
        @(posedge clock);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= {idx, 2'b00};
        pwdata  <= data;
        pstrb   <= strb;
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
        end while (pready !== 1'b1);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // Writes carry random upper bits, which the registers must ignore.
    task automatic wr(input logic [9:0] idx, input logic [7:0] val, input logic [3:0] strb = 4'hF);
        lfsr = lfsr_next(lfsr);
        apb(idx, 1'b1, {lfsr[31:8], val}, strb);
    endtask

    // A read notes its expectation before the transfer starts.
    task automatic rd(input logic [9:0] idx, input logic [31:0] exp, input logic err);
        notes.push_back('{exp, err});
        apb(idx, 1'b0, lfsr, 4'hF);
    endtask

    task automatic cmp_rd(input rd_note_t exp);
        checked++;
        if (prdata !== exp.data || pslverr !== exp.err) begin
            mismatches++;
            $display("ERROR %0t read got %h/%b expected %h/%b", $time, prdata, pslverr, exp.data, exp.err);
        end
    endtask

    task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // Interrupt and oscillator hold are sampled mid-cycle, once settled.
    task automatic chk(input logic irq_exp, input logic osc_exp);
        @(negedge clock);
        cmp_val({31'h0, irq}, {31'h0, irq_exp}, "irq");
        cmp_val({31'h0, osc_keep_on}, {31'h0, osc_exp}, "osc");
    endtask

    task automatic wait_irq(input int lim, output time t);
        int n;
        n = 0;
        do begin
            @(negedge clock);
            n++;
        end while (irq !== 1'b1 && n < lim);
        cmp_val({31'h0, irq}, 32'h0000_0001, "irq wait");
        t = $time;
    endtask

    // Runs one prescale code and measures the time between two rollovers.
    task automatic run_code(input logic [2:0] sel);
        logic [7:0] rl;
        int         per;
        time        t0;
        time        t1;
        lfsr = lfsr_next(lfsr);
        rl  = (sel == 3'h0) ? {5'h1E, lfsr[2:0]} : ((sel < 3'h4) ? 8'hFE : 8'hFF);
        per = (256 - rl) * nt[sel] * TDIV;
        wr(IDX_RELOAD, rl);
        rd(IDX_RELOAD, {24'h0, rl}, 1'b0);
        idle_mode  <= sel[0];
        power_down <= sel[1];
        wr(IDX_CONTROL, {3'h0, 2'b01, sel});
        chk(1'b0, 1'b1);
        wait_irq(per + 2 * TDIV * nt[sel] + 20, t0);
        wr(IDX_IRQ_CLEAR, 8'h01);
        wait_irq(per + 20, t1);
        cmp_val(32'((t1 - t0) / 50), per, "period");
        wr(IDX_CONTROL, 8'h00);
        chk(1'b0, 1'b0);
    endtask

    task automatic wrap_up();
        if (mismatches == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // ==========================================================
    // Result monitor and watchdog
    // ==========================================================
    // Each completed read takes the oldest note off the queue.
    always @(posedge clock) begin
        if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0) begin
            if (notes.size() == 0) begin
                mismatches++;
                $display("ERROR %0t read with no expectation", $time);
            end else begin
                cmp_rd(notes.pop_front());
            end
        end
    end

    // The watchdog allows about two and a half times the expected run length.
    initial begin
        repeat (80000) @(posedge clock);
        mismatches++;
        wrap_up();
    end

    // ==========================================================
    // Main sequence
    // ==========================================================
    initial begin
        clock      = 1'b0;
        resetn     = 1'b0;
        psel       = 1'b0;
        penable    = 1'b0;
        pwrite     = 1'b0;
        paddr      = '0;
        pwdata     = DATA_ZERO;
        pstrb      = 4'h0;
        idle_mode  = 1'b0;
        power_down = 1'b0;
        lfsr       = 32'h0000_b512;
        mismatches = 0;
        checked    = 0;
        repeat (5) @(posedge clock);
        resetn <= 1'b1;
        chk(1'b0, 1'b0);
        // The timer clock is given time to settle before anything relies on it.
        repeat (TDIV) @(posedge clock);
        foreach (idxs[i]) rd(idxs[i], DATA_ZERO, 1'b0);
        rd(10'h3FF, DATA_ZERO, 1'b1);
        wr(IDX_RELOAD, 8'h5A, 4'hE);
        rd(IDX_RELOAD, DATA_ZERO, 1'b0);
        wr(IDX_IRQ_ENABLE, 8'h01);
        wr(IDX_GLOBAL_EN, 8'h01);
        for (int s = 0; s < 8; s++) run_code(3'(s));
        wr(IDX_CONTROL, 8'h10);
        rd(IDX_CONTROL, 32'h0000_0010, 1'b0);
        chk(1'b1, 1'b0);
        wr(IDX_IRQ_STATUS, 8'h00);
        repeat (40) @(negedge clock);
        rd(IDX_IRQ_STATUS, 32'h0000_0001, 1'b0);
        wr(IDX_IRQ_ENABLE, 8'h00);
        chk(1'b0, 1'b0);
        wr(IDX_IRQ_ENABLE, 8'h01);
        wr(IDX_GLOBAL_EN, 8'h00);
        chk(1'b0, 1'b0);
        wr(IDX_GLOBAL_EN, 8'h01);
        chk(1'b1, 1'b0);
        wr(IDX_IRQ_CLEAR, 8'h01);
        rd(IDX_IRQ_STATUS, DATA_ZERO, 1'b0);
        repeat (300) @(negedge clock);
        chk(1'b0, 1'b0);
        wrap_up();
    end
endmodule
